/* File: maskable_irq_request_flags.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "irq_flags_consts.svh"

// Overview of operation
// - A source event sets its request flag regardless of any enable bit.
// - A pending flag requests service only with its enable and master enable set.
// - Software writing 1 to a flag sets it and requests like a hardware event.
// - A flag clears itself when the CPU accepts that request.
// - A write to request or enable registers delays service by one further instruction.
// - Timer 0 flag sits at bit 0, timer 1 flag at bit 1.
// - UART 0 flag at bit 0, RC converter flag at bit 5.
// - Timer 2 flag at bit 5, timer 3 flag at bit 6.
// - PWM0 bit 0, 1 kHz bit 4, 128 Hz bit 5, 32 Hz bit 7.
// - 16 Hz tick flag at bit 0, 2 Hz tick flag at bit 3.
// - All request registers are 8-bit read/write and reset to zero.
// - Highest-priority enabled pending source is served first, others stay pending.
module maskable_irq_request_flags #(
    parameter int NUM_REGS = 5,
    parameter int NUM_SRC = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire irq_flags_pkg::reg_req_s bus_req,
    output logic [7:0] rdata,
    input wire logic [NUM_SRC-1:0] src_event,
    input wire logic master_irq_enable,
    input wire logic irq_accept,
    input wire logic instr_done,
    output irq_flags_pkg::service_s service,
    output logic irq
);

    localparam int FLAT_W = NUM_REGS * 8;

    // Flat position of each source flag inside the request image. Every other
    // position is a spare bit that software may store but that never requests.
    function automatic logic [5:0] src_pos(input logic [3:0] idx);
        logic [5:0] pos;
        pos = `POS_TIMER0;
        unique case (irq_flags_pkg::source_e'(idx))
            irq_flags_pkg::SRC_TIMER0: pos = `POS_TIMER0;
            irq_flags_pkg::SRC_TIMER1: pos = `POS_TIMER1;
            irq_flags_pkg::SRC_UART0: pos = `POS_UART0;
            irq_flags_pkg::SRC_RCADC: pos = `POS_RCADC;
            irq_flags_pkg::SRC_TIMER2: pos = `POS_TIMER2;
            irq_flags_pkg::SRC_TIMER3: pos = `POS_TIMER3;
            irq_flags_pkg::SRC_PWM0: pos = `POS_PWM0;
            irq_flags_pkg::SRC_KHZ: pos = `POS_KHZ;
            irq_flags_pkg::SRC_TICK128: pos = `POS_TICK128;
            irq_flags_pkg::SRC_TICK32: pos = `POS_TICK32;
            irq_flags_pkg::SRC_TICK16: pos = `POS_TICK16;
            irq_flags_pkg::SRC_TICK2: pos = `POS_TICK2;
            default: pos = `POS_TIMER0;
        endcase
        return pos;
    endfunction

    // Stored state. Request and enable images are kept flat, one byte per
    // register, so bus access and per-source views index the same vector.
    logic [FLAT_W-1:0] req_q;
    logic [FLAT_W-1:0] req_d;
    logic [FLAT_W-1:0] en_q;
    logic [FLAT_W-1:0] en_d;
    logic [7:0] evt_status_q;
    logic [7:0] evt_status_d;
    logic [7:0] evt_mask_q;
    logic hold_q;
    logic hold_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic serv_req_q;
    logic serv_req_d;
    logic [3:0] serv_src_q;
    logic [3:0] serv_src_d;
    logic irq_q;
    logic irq_d;

    // Address decode of the register bus. Strobes are qualified here so the
    // registers below see one write enable each.
    wire req_hit;
    wire en_hit;
    wire status_hit;
    wire mask_hit;
    wire live_hit;
    wire [2:0] req_idx;
    wire [2:0] en_idx;
    wire req_wr;
    wire en_wr;
    wire mask_wr;
    wire status_rd;

    assign req_hit = (bus_req.addr >= `REQ_BASE_ADDR) && (bus_req.addr <= `REQ_SLOW_TICK_ADDR);
    assign en_hit = (bus_req.addr >= `EN_BASE_ADDR) && (bus_req.addr <= `EN_LAST_ADDR);
    assign status_hit = bus_req.addr == `EVT_STATUS_ADDR;
    assign mask_hit = bus_req.addr == `EVT_MASK_ADDR;
    assign live_hit = bus_req.addr == `LIVE_STATE_ADDR;
    assign req_idx = 3'(bus_req.addr - `REQ_BASE_ADDR);
    assign en_idx = 3'(bus_req.addr - `EN_BASE_ADDR);
    assign req_wr = bus_req.wr && req_hit;
    assign en_wr = bus_req.wr && en_hit;
    assign mask_wr = bus_req.wr && mask_hit;
    assign status_rd = bus_req.rd && status_hit;

    // Per-source event, enable and pending views of the flat images.
    wire [NUM_SRC-1:0] flag_now;
    wire [NUM_SRC-1:0] en_now;
    wire [NUM_SRC-1:0] pend;
    logic [FLAT_W-1:0] evt_flat;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            // Only mapped positions feed the request, so spare bits never do.
            assign flag_now[gi] = req_q[src_pos(4'(gi))];
            assign en_now[gi] = en_q[src_pos(4'(gi))];
            assign pend[gi] = flag_now[gi] && en_now[gi];
        end
    endgenerate

    // Scatter the source events onto their flag positions.
    // An event pulse therefore lands in the same byte that software reads back.
    always_comb begin
        evt_flat = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            evt_flat[src_pos(4'(i))] = src_event[i];
        end
    end

    // Highest priority is the lowest source index that is pending.
    // The loop runs downward so the last hit, the lowest index, is kept.
    logic [3:0] win_src;
    logic win_any;

    always_comb begin
        win_src = 4'h0;
        win_any = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win_src = 4'(i);
                win_any = 1'b1;
            end
        end
    end

    // Acceptance of the presented request and the flag it clears. The cleared
    // flag is the one named on the service port, not the current winner, so a
    // late higher-priority event keeps its own request.
    wire accept_now;
    wire [5:0] accept_pos;
    logic [FLAT_W-1:0] accept_clr;

    assign accept_now = irq_accept && serv_req_q;
    assign accept_pos = src_pos(serv_src_q);

    always_comb begin
        accept_clr = '0;
        accept_clr[accept_pos] = accept_now;
    end

    // Software writes replace a whole byte of the request image.
    // Writing 0 to a flag withdraws it; writing 1 raises it as an event would.
    logic [FLAT_W-1:0] req_written;

    always_comb begin
        req_written = req_q;
        if (req_wr) begin
            req_written[req_idx*8 +: 8] = bus_req.wdata;
        end
    end

    // Hardware clear first, then events win over both write and clear.
    // Dropping a fresh event would lose a request for good; a spare one is harmless.
    assign req_d = (req_written & ~accept_clr) | evt_flat;

    // Enable image, written byte by byte.
    // Enable writes never touch the request flags, so no event is lost.
    always_comb begin
        en_d = en_q;
        if (en_wr) begin
            en_d[en_idx*8 +: 8] = bus_req.wdata;
        end
    end

    // An event on a flag that was already set and not cleared is overrun.
    // An event on the flag being accepted in the same cycle is not counted.
    wire [NUM_SRC-1:0] overrun_src;
    wire [NUM_SRC-1:0] accept_hits;

    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_ovr
            assign accept_hits[gi] = accept_now && (serv_src_q == 4'(gi));
            assign overrun_src[gi] = src_event[gi] && flag_now[gi] && !accept_hits[gi];
        end
    endgenerate

    // Sticky status: a read clears it, a new event in that cycle still lands.
    // Clearing on the read strobe means the byte returned is the last one seen.
    wire [7:0] evt_now;

    assign evt_now = {6'h00, |overrun_src, accept_now};

    always_comb begin
        evt_status_d = evt_status_q;
        if (status_rd) begin
            evt_status_d = 8'h00;
        end
        evt_status_d = evt_status_d | evt_now;
    end

    // Writes to request or enable bytes hold off service until one more
    // instruction has completed, so the write's successor always runs.
    // A write in the same cycle as instr_done still starts a fresh hold.
    always_comb begin
        hold_d = hold_q;
        if (instr_done) begin
            hold_d = 1'b0;
        end
        if (req_wr || en_wr) begin
            hold_d = 1'b1;
        end
    end

    // Service request toward the core; dropped at once on acceptance.
    // The next hold value is tested too, so a write drops the request at once,
    // and the accept cycle is blocked so the cleared source is not shown again.
    wire serv_allowed;

    assign serv_allowed = master_irq_enable && !hold_q && !hold_d && !accept_now;

    always_comb begin
        serv_req_d = win_any && serv_allowed;
        serv_src_d = win_any ? win_src : serv_src_q;
    end

    // Level interrupt for unmasked sticky events.
    // It follows the next status value so a status bit and its interrupt rise together.
    assign irq_d = |(evt_status_d & evt_mask_q);

    // Read mux; unmapped addresses read as zero.
    // Outside a read slot the data is zero, so stale bytes never linger on the bus.
    wire [7:0] live_state;

    assign live_state = {serv_src_q, 2'b00, hold_q, serv_req_q};

    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            if (req_hit) begin
                rdata_d = req_q[req_idx*8 +: 8];
            end else if (en_hit) begin
                rdata_d = en_q[en_idx*8 +: 8];
            end else if (status_hit) begin
                rdata_d = evt_status_q;
            end else if (mask_hit) begin
                rdata_d = evt_mask_q;
            end else if (live_hit) begin
                rdata_d = live_state;
            end
        end
    end

    // Request image; a clean start leaves nothing pending.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            req_q <= {NUM_REGS{`REQ_RESET}};
        end else begin
            req_q <= req_d;
        end
    end

    // Enable image, cleared by reset so no source is live before software opts in.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            en_q <= {NUM_REGS{`EN_RESET}};
        end else begin
            en_q <= en_d;
        end
    end

    // Sticky event status.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            evt_status_q <= 8'h00;
        end else begin
            evt_status_q <= evt_status_d;
        end
    end

    // Event mask, written whole by software.
    // A mask change reaches the interrupt line one cycle after the write.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            evt_mask_q <= `EVT_MASK_RESET;
        end else if (mask_wr) begin
            evt_mask_q <= bus_req.wdata;
        end
    end

    // Post-write hold of service.
    // It is cleared by reset so the first request after reset is not delayed.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
        end
    end

    // Service request and the source it names, handed to the core.
    // Both move together so the core never sees a source from another cycle.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            serv_req_q <= 1'b0;
            serv_src_q <= 4'h0;
        end else begin
            serv_req_q <= serv_req_d;
            serv_src_q <= serv_src_d;
        end
    end

    // Read data register.
    // It holds a byte only in the cycle after a read strobe.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Interrupt line register.
    // Reset drops it with the status it reflects.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // All outputs come straight from the registers above.
    assign rdata = rdata_q;
    assign service = '{req: serv_req_q, src: serv_src_q};
    assign irq = irq_q;

endmodule

/* File: irq_flags_consts.svh */
`ifndef IRQ_FLAGS_CONSTS_SVH
`define IRQ_FLAGS_CONSTS_SVH

// Request registers, one byte each.
`define REQ_BASE_ADDR 16'hF01B
`define REQ_TIMER01_ADDR 16'hF01B
`define REQ_UART_RCADC_ADDR 16'hF01C
`define REQ_TIMER23_ADDR 16'hF01D
`define REQ_PWM_TICK_ADDR 16'hF01E
`define REQ_SLOW_TICK_ADDR 16'hF01F

// Per-source enable registers, one byte each, same layout as the requests.
`define EN_BASE_ADDR 16'hF013
`define EN_LAST_ADDR 16'hF017

// Event status, event mask and live state registers.
`define EVT_STATUS_ADDR 16'hF020
`define EVT_MASK_ADDR 16'hF021
`define LIVE_STATE_ADDR 16'hF022

// Reset values.
`define REQ_RESET 8'h00
`define EN_RESET 8'h00
`define EVT_MASK_RESET 8'h00

// Event status bit positions.
`define EVT_ACCEPT_BIT 0
`define EVT_OVERRUN_BIT 1

// Live state field positions.
`define LIVE_PEND_BIT 0
`define LIVE_HOLD_BIT 1
`define LIVE_SRC_LSB 4

// Flag positions in the 40-bit flat image, register index times 8 plus bit.
`define POS_TIMER0 6'h00
`define POS_TIMER1 6'h01
`define POS_UART0 6'h08
`define POS_RCADC 6'h0D
`define POS_TIMER2 6'h15
`define POS_TIMER3 6'h16
`define POS_PWM0 6'h18
`define POS_KHZ 6'h1C
`define POS_TICK128 6'h1D
`define POS_TICK32 6'h1F
`define POS_TICK16 6'h20
`define POS_TICK2 6'h23

`endif

/* File: irq_flags_pkg.sv */
package irq_flags_pkg;

    // One register bus request from the CPU side.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // Service request presented to the CPU core.
    typedef struct packed {
        logic req;
        logic [3:0] src;
    } service_s;

    // Sources in falling priority order, ranks 10 to 21.
    typedef enum logic [3:0] {
        SRC_TIMER0,
        SRC_TIMER1,
        SRC_UART0,
        SRC_RCADC,
        SRC_TIMER2,
        SRC_TIMER3,
        SRC_PWM0,
        SRC_KHZ,
        SRC_TICK128,
        SRC_TICK32,
        SRC_TICK16,
        SRC_TICK2
    } source_e;

endpackage

/* File: irq_flags_properties.sv */
`timescale 1ns/1ps
`include "irq_flags_consts.svh"
// Port-level checks of the request flag block.
module irq_flags_checker #(
    parameter int NUM_SRC = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire irq_flags_pkg::reg_req_s bus_req,
    input wire logic [7:0] rdata,
    input wire logic [NUM_SRC-1:0] src_event,
    input wire logic master_irq_enable,
    input wire logic irq_accept,
    input wire logic instr_done,
    input wire irq_flags_pkg::service_s service,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Writes to request or enable bytes start a hold of service.
    wire req_wr = bus_req.wr && bus_req.addr >= `REQ_BASE_ADDR
        && bus_req.addr <= `REQ_SLOW_TICK_ADDR;
    wire en_wr = bus_req.wr && bus_req.addr >= `EN_BASE_ADDR
        && bus_req.addr <= `EN_LAST_ADDR;
    property p_needs_master;
        service.req |-> $past(master_irq_enable);
    endproperty
    a_needs_master: assert property (p_needs_master) else $error("service without master");
    property p_stays;
        service.req && !irq_accept && master_irq_enable && !bus_req.wr && !$past(bus_req.wr)
            |=> service.req;
    endproperty
    a_stays: assert property (p_stays) else $error("service dropped early");
    property p_accept_drop;
        irq_accept && service.req |=> !service.req;
    endproperty
    a_accept_drop: assert property (p_accept_drop) else $error("service kept after accept");
    property p_src_range;
        service.req |-> service.src <= 4'hB;
    endproperty
    a_src_range: assert property (p_src_range) else $error("source out of range");
    property p_req_hold;
        req_wr |-> ##2 !service.req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("no hold after request write");
    property p_en_hold;
        en_wr ##1 !instr_done |-> ##2 !service.req;
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("no hold after enable write");
    property p_rdata_idle;
        !bus_req.rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_reset_clean;
        $rose(rst_n) |-> service == 5'h00 && !irq && rdata == 8'h00;
    endproperty
    a_reset_clean: assert property (p_reset_clean) else $error("outputs not reset");
endmodule

bind maskable_irq_request_flags irq_flags_checker #(.NUM_SRC(NUM_SRC)) u_chk (.mclk(mclk),
    .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .src_event(src_event),
    .master_irq_enable(master_irq_enable), .irq_accept(irq_accept),
    .instr_done(instr_done), .service(service), .irq(irq));

/* File: cpu_model.sv */
`timescale 1ns/1ps
// Core side: accepts presented requests and retires instructions.
module cpu_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire irq_flags_pkg::service_s service,
    input wire logic slow,
    output logic irq_accept = 1'b0,
    output logic instr_done = 1'b0
);
    int wait_cnt = 0;
    int step_cnt = 0;
    // One accept pulse per request, after a short or a long look.
    always @(posedge mclk) begin
        if (!rst_n || irq_accept || !service.req) begin
            irq_accept <= 1'b0;
            wait_cnt <= 0;
        end else if (wait_cnt >= (slow ? 3 : 0)) begin
            irq_accept <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
    // An instruction retires every fourth cycle.
    always @(posedge mclk) begin
        step_cnt <= rst_n ? step_cnt + 1 : 0;
        instr_done <= rst_n && step_cnt % 4 == 3;
    end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    irq_flags_pkg::reg_req_s bus_req = '0;
    logic [11:0] src_event = '0;
    logic master_irq_enable = 1'b0;
    logic slow = 1'b0;
    logic irq_accept;
    logic instr_done;
    logic [7:0] rdata;
    irq_flags_pkg::service_s service;
    logic irq;
    logic [7:0] val;
    logic [7:0] d;
    logic ovr = 1'b0;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 16;
    int img[5];
    int pos[12] = '{0, 1, 8, 13, 21, 22, 24, 28, 29, 31, 32, 35};
    int own[5] = '{8'h03, 8'h21, 8'h60, 8'hB1, 8'h09};
    int got[$];

    always #10 mclk = ~mclk;

    maskable_irq_request_flags u_dut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
        .rdata(rdata), .src_event(src_event), .master_irq_enable(master_irq_enable),
        .irq_accept(irq_accept), .instr_done(instr_done), .service(service), .irq(irq));
    cpu_model u_cpu (.mclk(mclk), .rst_n(rst_n), .service(service), .slow(slow),
        .irq_accept(irq_accept), .instr_done(instr_done));

    task automatic check(logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] v);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(logic [15:0] a);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1 val = rdata;
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Records every accepted source and cuts a hang short.
    always @(posedge mclk) begin
        cycles++;
        if (irq_accept && service.req) got.push_back(service.src);
        if (cycles > 5000) begin
            num_errors++;
            complete_run();
        end
    end

    // Main sequence.
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(16'hF01B + 16'(i));
            check(val, 8'h00);
            d = 8'($random(seed));
            wr(16'hF01B + 16'(i), d);
            rd(16'hF01B + 16'(i));
            check(val, d);
            img[i] = d;
            wr(16'hF013 + 16'(i), 8'hFF);
        end
        rd(16'hF030);
        check(val, 8'h00);
        wr(16'hF021, 8'h03);
        for (int s = 0; s < 12; s++) begin
            @(posedge mclk);
            if (img[pos[s] / 8][pos[s] % 8]) ovr = 1'b1;
            img[pos[s] / 8] |= 1 << (pos[s] % 8);
            src_event <= 12'(1 << s);
        end
        @(posedge mclk);
        src_event <= '0;
        for (int i = 0; i < 5; i++) begin
            rd(16'hF01B + 16'(i));
            check(val, img[i][7:0]);
        end
        check(8'(got.size()), 8'h00);
        @(posedge mclk);
        slow <= 1'b1;
        master_irq_enable <= 1'b1;
        for (int k = 0; k < 400 && got.size() < 12; k++) @(posedge mclk);
        check(8'(got.size()), 8'h0C);
        for (int s = 0; s < 12; s++) check(8'(got[s]), 8'(s));
        slow <= 1'b0;
        wr(16'hF01B, 8'h02);
        img[0] = 8'h02;
        for (int k = 0; k < 100 && got.size() < 13; k++) @(posedge mclk);
        check(8'(got.size()), 8'h0D);
        check(8'(got[12]), 8'h01);
        for (int i = 0; i < 5; i++) begin
            rd(16'hF01B + 16'(i));
            check(val, 8'(img[i] & ~own[i]));
        end
        wr(16'hF013, 8'h00);
        wr(16'hF01B, 8'h01);
        settle(10);
        check(8'(got.size()), 8'h0D);
        wr(16'hF013, 8'h03);
        for (int k = 0; k < 100 && got.size() < 14; k++) @(posedge mclk);
        check(8'(got.size()), 8'h0E);
        check(8'(got[13]), 8'h00);
        settle(2);
        check(irq, 1'b1);
        wr(16'hF021, 8'h00);
        settle(2);
        check(irq, 1'b0);
        wr(16'hF021, 8'h03);
        settle(2);
        check(irq, 1'b1);
        rd(16'hF020);
        check(val, {6'h00, ovr, 1'b1});
        settle(2);
        check(irq, 1'b0);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(16'hF01B + 16'(i));
            check(val, 8'h00);
        end
        complete_run();
    end
endmodule
